// ==== core/host_port_pkg.sv ====
package host_port_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_PIXEL        = 8'h00;
    localparam logic [7:0] ADDR_TABLE_SEL    = 8'h03;
    localparam logic [7:0] ADDR_TABLE_HI     = 8'h04;
    localparam logic [7:0] ADDR_TABLE_LO     = 8'h05;
    localparam logic [7:0] ADDR_TABLE_WINDOW = 8'h06;
    localparam logic [7:0] ADDR_READ_CONFIG  = 8'h2A;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TABLE_TYPE_BIT   = 0;
    localparam int TABLE_COLOR_LSB  = 1;
    localparam int NIBBLE_MODE_BIT  = 0;
    localparam int TABLE_ADDR_WIDTH = 13;
    localparam int TABLE_HI_BITS    = 5;

    // ****************************************
    // Table ranges
    // ****************************************
    localparam logic [12:0] GAMMA_LAST     = 13'h03FF;
    localparam logic [12:0] COEF_LAST_300  = 13'h0AA9;
    localparam logic [12:0] COEF_LAST_600  = 13'h1554;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  ADDR_RESET       = 8'h00;
    localparam logic [2:0]  TABLE_SEL_RESET  = 3'h0;
    localparam logic [12:0] TABLE_ADDR_RESET = 13'h0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int RELEASE_MCLKS   = 2;
    localparam int RELEASE_CYCLES  = (RELEASE_MCLKS < 1) ? 1 : RELEASE_MCLKS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_NIB1,
        ST_RD_NIB2,
        ST_RD_DONE
    } port_state_e;

endpackage

// ==== core/strobe_sync.sv ====
`timescale 1ns/1ns

// ****************************************
// Two-stage synchroniser with edge flags
// ****************************************
module strobe_sync (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~last_q;
    assign fall_o  = ~sync_q & last_q;

endmodule

// ==== core/table_addr_counter.sv ====
`timescale 1ns/1ns

// ****************************************
// Table window address counter
// ****************************************
module table_addr_counter (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        load_hi_i,
    input  wire logic        load_lo_i,
    input  wire logic [7:0]  load_data_i,
    input  wire logic        coef_mode_i,
    input  wire logic        hi_res_i,
    input  wire logic        step_i,
    output logic      [12:0] addr_o,
    output logic             odd_byte_o
);

    logic [12:0] addr_q;
    logic        odd_q;
    logic [12:0] last;

    assign last = coef_mode_i ? (hi_res_i ? host_port_pkg::COEF_LAST_600
                                          : host_port_pkg::COEF_LAST_300)
                              : host_port_pkg::GAMMA_LAST;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_q <= host_port_pkg::TABLE_ADDR_RESET;
            odd_q  <= 1'b0;
        end else if (load_hi_i) begin
            addr_q <= {load_data_i[host_port_pkg::TABLE_HI_BITS-1:0], addr_q[7:0]};
            odd_q  <= 1'b0;
        end else if (load_lo_i) begin
            addr_q <= {addr_q[12:8], load_data_i};
            odd_q  <= 1'b0;
        end else if (step_i) begin
            if (coef_mode_i && !odd_q) begin
                odd_q <= 1'b1;
            end else begin
                odd_q  <= 1'b0;
                addr_q <= (addr_q >= last) ? 13'h0000 : addr_q + 13'h0001;
            end
        end
    end

    assign addr_o     = addr_q;
    assign odd_byte_o = odd_q;

    a_addr_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
        step_i && !load_hi_i && !load_lo_i && addr_q >= last
            && (!coef_mode_i || odd_q) |=> addr_q == 13'h0000)
        else $error("table address did not wrap");

endmodule

// ==== core/scanner_host_port_handshake.sv ====
`timescale 1ns/1ns

// Overview of operation
// - Init pulse low-high makes port transparent within 2-3 clocks.
// - Transparency by init alone keeps scan and operating state running.
// - Init with autofeed, select-in, strobe all pulsed also resets the device.
// - All parallel-port writes outside micro mode use the EPP-style handshake, even nibble mode; micro writes raise no busy.
// - Writes are an address cycle followed by a data cycle.
// - Device latches byte, raises busy, drops busy on qualifier rise.
// - Data write is the same handshake qualified by autofeed.
// - Last address is kept; consecutive data writes target it.
// - Byte read drives data then busy; on autofeed rise floats then drops busy.
// - Consecutive reads return from the last written address.
// - Nibble mode shows low nibble on status lines then raises busy.
// - Autofeed rise gives high nibble on same lines, then busy falls.
// - Interface select high maps rd, wr, cs, ale onto port lines.
// - Micro mode latches the address from the bus on strobe fall.
// - Micro mode reads return data from the latched address repeatedly.
// - Table address steps per gamma byte or every second coefficient byte.
// - Table reads step address per gamma byte or every second coefficient byte.
// - Table select: bit 0 type, bits 2:1 colour.
// - Register 42 bit 0 picks byte or nibble reads, no reset default.
// - Table address wraps to zero at 1023, 2729 or 5460.
module scanner_host_port_handshake (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       host_interface_select_i,
    input  wire logic       hi_res_sensor_i,
    input  wire logic       wake_i,
    input  wire logic       strobe_n_i,
    input  wire logic       autofeed_n_i,
    input  wire logic       init_n_i,
    input  wire logic       select_in_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_n_o,
    output logic            busy_o,
    output logic            ack_n_o,
    output logic            paper_end_o,
    output logic            select_o,
    output logic            error_n_o,
    output logic            status_oe_n_o,
    output logic            printer_hold_o,
    output logic            printer_isolate_o,
    output logic            device_reset_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic [7:0] table_rdata_i,
    output logic      [2:0] table_sel_o,
    output logic     [12:0] table_addr_o,
    output logic            table_odd_byte_o,
    output logic            nibble_mode_o,
    output logic            active_o
);

    // ****************************************
    // Strobe synchronisers
    // ****************************************
    logic stb_lvl, stb_rise, stb_fall;
    logic afd_lvl, afd_rise, afd_fall;
    logic ini_lvl, ini_rise, ini_fall;
    logic sel_lvl, sel_rise, sel_fall;

    strobe_sync u_sync_stb (.clk_i(clk_i), .reset_i(reset_i), .async_i(strobe_n_i),
        .level_o(stb_lvl), .rise_o(stb_rise), .fall_o(stb_fall));
    strobe_sync u_sync_afd (.clk_i(clk_i), .reset_i(reset_i), .async_i(autofeed_n_i),
        .level_o(afd_lvl), .rise_o(afd_rise), .fall_o(afd_fall));
    strobe_sync u_sync_ini (.clk_i(clk_i), .reset_i(reset_i), .async_i(init_n_i),
        .level_o(ini_lvl), .rise_o(ini_rise), .fall_o(ini_fall));
    strobe_sync u_sync_sel (.clk_i(clk_i), .reset_i(reset_i), .async_i(select_in_n_i),
        .level_o(sel_lvl), .rise_o(sel_rise), .fall_o(sel_fall));

    logic upmode;
    assign upmode = host_interface_select_i;

    // ****************************************
    // Transparency control
    // ****************************************
    logic active_q;
    logic all_low_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            all_low_q <= 1'b0;
        end else if (!upmode && ini_fall) begin
            all_low_q <= ~afd_lvl & ~sel_lvl & ~stb_lvl;
        end else if (!upmode && ini_rise) begin
            all_low_q <= 1'b0;
        end else if (!upmode && !ini_lvl && (afd_lvl || sel_lvl || stb_lvl)) begin
            all_low_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active_q <= 1'b0;
        end else if (!upmode && ini_rise) begin
            active_q <= 1'b0;
        end else if (upmode || wake_i) begin
            active_q <= 1'b1;
        end
    end

    // Reset pulse leaves operating state alone unless all four pulsed
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            device_reset_o <= 1'b0;
        end else begin
            device_reset_o <= !upmode && ini_rise && all_low_q && afd_rise && sel_rise
                              && stb_rise;
        end
    end

    assign active_o          = active_q;
    assign printer_hold_o    = ~active_q;
    assign printer_isolate_o = active_q;
    assign status_oe_n_o     = ~active_q;

    // ****************************************
    // Address and table selection
    // ****************************************
    logic [7:0] addr_q;
    logic [2:0] table_sel_q;
    logic       nibble_q;
    logic       wr_addr, wr_data, rd_start;
    logic [7:0] wdata_q;

    host_port_pkg::port_state_e state_q;

    // Parallel strobes ignored while init is low
    logic port_live;
    assign port_live = active_q && (upmode || ini_lvl);

    // Micro mode: cs = init low, ale = select-in low, wr = strobe, rd = autofeed
    assign wr_addr = port_live && (upmode
                     ? (!ini_lvl && !sel_lvl && stb_fall)
                     : (state_q == host_port_pkg::ST_IDLE && !stb_lvl && sel_fall));
    assign wr_data = port_live && (upmode
                     ? (!ini_lvl && sel_lvl && stb_fall)
                     : (state_q == host_port_pkg::ST_IDLE && !stb_lvl && afd_fall));
    assign rd_start = port_live && (upmode
                     ? (!ini_lvl && afd_fall)
                     : (state_q == host_port_pkg::ST_IDLE && stb_lvl && afd_fall));

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_q  <= host_port_pkg::ADDR_RESET;
            wdata_q <= 8'h00;
        end else if (wr_addr) begin
            addr_q <= data_i;
        end else if (wr_data) begin
            wdata_q <= data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            table_sel_q <= host_port_pkg::TABLE_SEL_RESET;
        end else if (wr_data && addr_q == host_port_pkg::ADDR_TABLE_SEL) begin
            table_sel_q <= data_i[2:0];
        end
    end

    // No reset default on the read-width bit
    always_ff @(posedge clk_i) begin
        if (wr_data && addr_q == host_port_pkg::ADDR_READ_CONFIG) begin
            nibble_q <= data_i[host_port_pkg::NIBBLE_MODE_BIT];
        end
    end

    logic is_window;
    assign is_window = addr_q == host_port_pkg::ADDR_TABLE_WINDOW;

    table_addr_counter u_tac (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .load_hi_i  (wr_data && addr_q == host_port_pkg::ADDR_TABLE_HI),
        .load_lo_i  (wr_data && addr_q == host_port_pkg::ADDR_TABLE_LO),
        .load_data_i(data_i),
        .coef_mode_i(table_sel_q[host_port_pkg::TABLE_TYPE_BIT]),
        .hi_res_i   (hi_res_sensor_i),
        .step_i     (is_window && (wr_data || rd_start)),
        .addr_o     (table_addr_o),
        .odd_byte_o (table_odd_byte_o)
    );

    assign table_sel_o   = table_sel_q;
    assign nibble_mode_o = nibble_q;
    assign reg_addr_o    = addr_q;
    assign reg_wdata_o   = wdata_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_wr_o <= 1'b0;
            reg_rd_o <= 1'b0;
        end else begin
            reg_wr_o <= wr_data;
            reg_rd_o <= rd_start;
        end
    end

    // ****************************************
    // Handshake state machine
    // ****************************************
    logic [7:0] rbyte;
    assign rbyte = is_window ? table_rdata_i : reg_rdata_i;

    logic [7:0] hold_q;
    logic       busy_q;
    logic       drive_q;
    logic [3:0] nib_q;

    always_ff @(posedge clk_i) begin
        if (reset_i || !active_q) begin
            state_q <= host_port_pkg::ST_IDLE;
            busy_q  <= 1'b0;
            drive_q <= 1'b0;
            hold_q  <= 8'h00;
            nib_q   <= 4'h0;
        end else begin
            case (state_q)
                host_port_pkg::ST_IDLE: begin
                    if (!upmode && (wr_addr || wr_data)) begin
                        busy_q  <= 1'b1;
                        state_q <= host_port_pkg::ST_WR_ACK;
                    end else if (rd_start) begin
                        hold_q <= rbyte;
                        if (!upmode && nibble_q) begin
                            nib_q   <= rbyte[3:0];
                            state_q <= host_port_pkg::ST_RD_NIB1;
                        end else begin
                            drive_q <= 1'b1;
                            state_q <= host_port_pkg::ST_RD_BYTE;
                        end
                    end
                end
                host_port_pkg::ST_WR_ACK: begin
                    if (sel_rise || afd_rise) begin
                        busy_q  <= 1'b0;
                        state_q <= host_port_pkg::ST_IDLE;
                    end
                end
                host_port_pkg::ST_RD_BYTE: begin
                    if (!upmode) begin
                        busy_q <= 1'b1;
                    end
                    if (afd_rise) begin
                        drive_q <= 1'b0;
                        state_q <= host_port_pkg::ST_RD_DONE;
                    end
                end
                host_port_pkg::ST_RD_DONE: begin
                    busy_q  <= 1'b0;
                    state_q <= host_port_pkg::ST_IDLE;
                end
                host_port_pkg::ST_RD_NIB1: begin
                    busy_q <= 1'b1;
                    if (afd_rise) begin
                        nib_q   <= hold_q[7:4];
                        state_q <= host_port_pkg::ST_RD_NIB2;
                    end
                end
                host_port_pkg::ST_RD_NIB2: begin
                    busy_q  <= 1'b0;
                    state_q <= host_port_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= host_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Second nibble stays up after busy falls, until a new cycle starts
    logic nib_last_q;
    always_ff @(posedge clk_i) begin
        if (reset_i || !active_q) begin
            nib_last_q <= 1'b0;
        end else if (state_q == host_port_pkg::ST_RD_NIB2) begin
            nib_last_q <= 1'b1;
        end else if (wr_addr || wr_data || rd_start) begin
            nib_last_q <= 1'b0;
        end
    end

    logic nib_show;
    assign nib_show = state_q == host_port_pkg::ST_RD_NIB1
                      || state_q == host_port_pkg::ST_RD_NIB2
                      || (nib_last_q && state_q == host_port_pkg::ST_IDLE);

    assign data_o      = hold_q;
    assign data_oe_n_o = ~(drive_q && active_q);
    assign busy_o      = busy_q;
    assign error_n_o   = nib_show ? nib_q[0] : 1'b1;
    assign select_o    = nib_show ? nib_q[1] : 1'b0;
    assign paper_end_o = nib_show ? nib_q[2] : 1'b0;
    assign ack_n_o     = nib_show ? nib_q[3] : 1'b1;

    // ****************************************
    // Checks
    // ****************************************
    a_release_time: assert property (@(posedge clk_i) disable iff (reset_i)
        !upmode && $rose(init_n_i)
            |-> ##[2:3] (printer_hold_o && !printer_isolate_o && data_oe_n_o && status_oe_n_o))
        else $error("init release too slow");
    a_init_release: assert property (@(posedge clk_i) disable iff (reset_i)
        !upmode && ini_rise |=> printer_hold_o && !printer_isolate_o && data_oe_n_o)
        else $error("init release did not go transparent");
    a_write_busy: assert property (@(posedge clk_i) disable iff (reset_i)
        !upmode && state_q == host_port_pkg::ST_IDLE && wr_addr && active_q
            |=> busy_o ##0 state_q == host_port_pkg::ST_WR_ACK)
        else $error("write not acknowledged");
    a_busy_drop: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == host_port_pkg::ST_WR_ACK && sel_rise && active_q && !ini_rise
            |=> !busy_o)
        else $error("busy held after qualifier rise");
    a_addr_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_data |=> $stable(addr_q))
        else $error("data write moved address");
    a_bus_float: assert property (@(posedge clk_i) disable iff (reset_i)
        !data_oe_n_o |-> state_q == host_port_pkg::ST_RD_BYTE)
        else $error("bus driven outside read");
    a_byte_float: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == host_port_pkg::ST_RD_BYTE && afd_rise && active_q && !ini_rise
            |=> data_oe_n_o ##1 !busy_o)
        else $error("byte read did not end");
    a_nib_second: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == host_port_pkg::ST_RD_NIB1 && afd_rise && active_q && !ini_rise
            |=> nib_q == $past(hold_q[7:4]) ##1 !busy_o)
        else $error("second nibble wrong");
    a_up_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        upmode && active_q && !ini_lvl && !sel_lvl && stb_fall |=> addr_q == $past(data_i))
        else $error("micro address not latched");

    c_write: cover property (@(posedge clk_i) wr_data && !upmode);
    c_byte_read: cover property (@(posedge clk_i) state_q == host_port_pkg::ST_RD_BYTE);
    c_nibble_read: cover property (@(posedge clk_i) state_q == host_port_pkg::ST_RD_NIB2);
    c_full_reset: cover property (@(posedge clk_i) device_reset_o);

endmodule

// ==== sim/host_port_model.sv ====
`timescale 1ns/1ns

// ****
// Parallel port host
// ****
module host_port_model (
    input  wire logic       clk_i,
    input  wire logic       busy_i,
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_oe_n_i,
    input  wire logic [3:0] nib_i,
    output logic            strobe_n_o,
    output logic            autofeed_n_o,
    output logic            init_n_o,
    output logic            select_in_n_o,
    output logic      [7:0] bus_o
);
    logic [7:0] hd;
    logic       hdrv;
    int         late_cnt;

    // Floating bus shows inverse of last value
    assign bus_o = !dev_oe_n_i ? dev_data_i : (hdrv ? hd : ~hd);

    initial begin
        {strobe_n_o, autofeed_n_o, init_n_o, select_in_n_o} = 4'hF;
        hd = 8'h00;
        hdrv = 1'b0;
        late_cnt = 0;
    end

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy_i !== lvl && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (busy_i !== lvl) late_cnt++;
        #1;
    endtask

    task automatic ep_write(input logic is_addr, input logic [7:0] b);
        tick();
        strobe_n_o = 1'b0;
        tick();
        hd = b;
        hdrv = 1'b1;
        tick();
        if (is_addr) select_in_n_o = 1'b0;
        else autofeed_n_o = 1'b0;
        wait_busy(1'b1);
        {strobe_n_o, autofeed_n_o, select_in_n_o} = 3'h7;
        wait_busy(1'b0);
        hdrv = 1'b0;
    endtask

    task automatic ep_read(output logic [7:0] b);
        tick();
        autofeed_n_o = 1'b0;
        wait_busy(1'b1);
        b = bus_o;
        autofeed_n_o = 1'b1;
        wait_busy(1'b0);
    endtask

    task automatic nib_read(output logic [7:0] b);
        tick();
        autofeed_n_o = 1'b0;
        wait_busy(1'b1);
        b[3:0] = nib_i;
        autofeed_n_o = 1'b1;
        wait_busy(1'b0);
        b[7:4] = nib_i;
    endtask

    task automatic init_pulse(input logic full);
        tick();
        init_n_o = 1'b0;
        if (full) {strobe_n_o, autofeed_n_o, select_in_n_o} = 3'h0;
        repeat (4) tick();
        {strobe_n_o, autofeed_n_o, init_n_o, select_in_n_o} = 4'hF;
    endtask

    // Micro bus cycle: ale picks address, rd picks read
    task automatic up_cycle(input logic ale, input logic rd, input logic [7:0] b,
                            output logic [7:0] q);
        tick();
        init_n_o = 1'b0;
        select_in_n_o = ~ale;
        hd = b;
        hdrv = ~rd;
        tick();
        if (rd) autofeed_n_o = 1'b0;
        else strobe_n_o = 1'b0;
        repeat (8) tick();
        q = bus_o;
        {strobe_n_o, autofeed_n_o} = 2'h3;
        tick();
        {init_n_o, select_in_n_o} = 2'h3;
        hdrv = 1'b0;
    endtask
endmodule

// ==== sim/scanner_host_port_handshake_tb_top.sv ====
`timescale 1ns/1ns

module scanner_host_port_handshake_tb_top;
    localparam logic [7:0] ADDR_RD_CFG = host_port_pkg::ADDR_READ_CONFIG;
    logic clk_i, reset_i, mode, wake, hires, st_n, af_n, in_n, si_n, busy, oe_n, hold, iso;
    logic ack_n, pe, sel, err_n, soe_n, drst, reg_wr, reg_rd, nib, act, todd;
    logic [7:0] din, dout, raddr, rwdata, q, la, lw;
    logic [2:0] tsel;
    logic [12:0] taddr;
    int error_cnt, total_checks, wr_cnt, rst_cnt, r0;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    scanner_host_port_handshake scanner_host_port_handshake_i (
        .clk_i(clk_i), .reset_i(reset_i), .host_interface_select_i(mode),
        .hi_res_sensor_i(hires), .wake_i(wake), .strobe_n_i(st_n), .autofeed_n_i(af_n),
        .init_n_i(in_n), .select_in_n_i(si_n), .data_i(din), .data_o(dout),
        .data_oe_n_o(oe_n), .busy_o(busy), .ack_n_o(ack_n), .paper_end_o(pe),
        .select_o(sel), .error_n_o(err_n), .status_oe_n_o(soe_n), .printer_hold_o(hold),
        .printer_isolate_o(iso), .device_reset_o(drst), .reg_wr_o(reg_wr),
        .reg_addr_o(raddr), .reg_wdata_o(rwdata), .reg_rd_o(reg_rd),
        .reg_rdata_i(raddr ^ 8'hA5), .table_rdata_i(taddr[7:0]), .table_sel_o(tsel),
        .table_addr_o(taddr), .table_odd_byte_o(todd), .nibble_mode_o(nib), .active_o(act));

    host_port_model host_port_model_i (
        .clk_i(clk_i), .busy_i(busy), .dev_data_i(dout), .dev_oe_n_i(oe_n),
        .nib_i({ack_n, pe, sel, err_n}), .strobe_n_o(st_n), .autofeed_n_o(af_n),
        .init_n_o(in_n), .select_in_n_o(si_n), .bus_o(din));

    always @(posedge clk_i) begin
        if (reg_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            la <= raddr;
            lw <= rwdata;
        end
        if (drst === 1'b1) rst_cnt <= rst_cnt + 1;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        int c0;
        c0 = wr_cnt;
        host_port_model_i.ep_write(1'b1, a);
        host_port_model_i.ep_write(1'b0, d);
        repeat (2) @(posedge clk_i);
        check({wr_cnt - c0 == 1, la, lw}, {1'b1, a, d});
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wake_up();
        @(posedge clk_i);
        #1 wake = 1'b1;
        @(posedge clk_i);
        #1 wake = 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        #300000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        {error_cnt, total_checks, wr_cnt, rst_cnt} = '0;
        {reset_i, mode, wake, hires} = 4'b1000;
        repeat (12) @(posedge clk_i);
        #1 reset_i = 1'b0;
        repeat (4) @(posedge clk_i);
        check({hold, iso, oe_n, busy}, 4'hA);
        wake_up();
        check({hold, iso, soe_n, ack_n, err_n, pe, sel}, 7'h2C);
        reg_write(ADDR_RD_CFG, 8'h00);
        check(nib, 1'b0);
        reg_write(8'h10, 8'h11);
        host_port_model_i.ep_write(1'b0, 8'h22);
        repeat (2) @(posedge clk_i);
        check({la, lw}, 16'h1022);
        repeat (2) begin
            host_port_model_i.ep_read(q);
            check({q, oe_n}, {8'hB5, 1'b1});
        end
        reg_write(8'h03, 8'h00);
        reg_write(8'h04, 8'h03);
        reg_write(8'h05, 8'hFF);
        check({tsel, taddr}, {3'h0, 13'h03FF});
        host_port_model_i.ep_write(1'b1, 8'h06);
        host_port_model_i.ep_write(1'b0, 8'hAB);
        check(taddr, 13'h0000);
        reg_write(8'h03, 8'h05);
        reg_write(8'h04, 8'h0A);
        reg_write(8'h05, 8'hA9);
        host_port_model_i.ep_write(1'b1, 8'h06);
        host_port_model_i.ep_write(1'b0, 8'h01);
        check({tsel, taddr}, {3'h5, 13'h0AA9});
        host_port_model_i.ep_write(1'b0, 8'h02);
        check(taddr, 13'h0000);
        hires = 1'b1;
        reg_write(8'h04, 8'h15);
        reg_write(8'h05, 8'h53);
        host_port_model_i.ep_write(1'b1, 8'h06);
        repeat (2) host_port_model_i.ep_write(1'b0, 8'h03);
        check(taddr, 13'h1554);
        repeat (2) host_port_model_i.ep_write(1'b0, 8'h04);
        check(taddr, 13'h0000);
        reg_write(8'h03, 8'h00);
        reg_write(8'h04, 8'h00);
        reg_write(8'h05, 8'h00);
        host_port_model_i.ep_write(1'b1, 8'h06);
        for (int i = 0; i < 2; i++) begin
            host_port_model_i.ep_read(q);
            check({q, taddr}, {i[7:0], 13'(i + 1)});
        end
        reg_write(ADDR_RD_CFG, 8'h01);
        check(nib, 1'b1);
        host_port_model_i.ep_write(1'b1, 8'h10);
        host_port_model_i.nib_read(q);
        check(q, 8'hB5);
        r0 = rst_cnt;
        host_port_model_i.init_pulse(1'b0);
        repeat (8) @(posedge clk_i);
        check({hold, iso, oe_n, soe_n, act, rst_cnt == r0}, 6'h2D);
        wake_up();
        host_port_model_i.init_pulse(1'b1);
        repeat (8) @(posedge clk_i);
        check({hold, iso, oe_n, rst_cnt == r0 + 1}, 4'hB);
        #1 mode = 1'b1;
        repeat (4) @(posedge clk_i);
        host_port_model_i.up_cycle(1'b1, 1'b0, 8'h10, q);
        host_port_model_i.up_cycle(1'b0, 1'b0, 8'h5A, q);
        repeat (2) @(posedge clk_i);
        check({la, lw}, 16'h105A);
        host_port_model_i.up_cycle(1'b0, 1'b1, 8'h00, q);
        check(q, 8'hB5);
        check(24'(host_port_model_i.late_cnt), 24'h000000);
        give_verdict();
    end
endmodule
